/* src/ccp_unit.sv */
// Overview of operation
// - pwm waveform on output pin, 10-bit duty
// - period is (limit+1)*4*Tosc*prescale
// - period match clears timer, sets pin unless new duty is zero, loads duty
// - postscaler plays no part in period
// - duty = upper buffer : control bits 5-4
// - duty writes anytime, applied at next period
// - active duty register read-only in pwm mode
// - duty double-buffered with hidden 2-bit latch
// - time base = timer plus phase or prescaler bits
// - pin cleared when time base equals active duty
// - duty beyond period leaves pin unchanged
// - full 10-bit resolution only at limit 255
// - sleep freezes timer, unit state and pin; a pending timer reset can still fire on a tick in sleep
// - reset clears registers except limit (0xff) and pin dir (1), pin becomes input
// - control bits 7-6 read zero, ignore writes
// - mode 11xx pwm, 0000 off and reset
// - modes 0100-0111 capture fall/rise/4th/16th
// - modes 0010/1000/1001 toggle/set/clear on match
// - 1010 flag only, 1011 flag plus trigger
// - clearing control forces compare latch low
// - capture prescaler cleared when off or not capture
// - capture copies 16-bit timer, sets flag
// - trigger at match, timer reset at next tick
//
// The placing of the registers and the address-and-strobe port are this design's own decisions.
`timescale 1ns/1ps
module ccp_unit (
    input wire logic clk, // system clock, 10 MHz
    input wire logic nrst, // async reset, active low
    input wire logic [3:0] addr, // register address
    input wire logic [7:0] wdata, // write data
    input wire logic wr_stb, // write strobe
    input wire logic rd_stb, // read strobe
    output logic [7:0] rdata, // read data, cycle after read strobe
    input wire logic sleep, // low-power sleep request
    input wire logic capture_in, // capture input pin level
    input wire logic [15:0] capture_timer_value, // external 16-bit timer
    input wire logic capture_timer_tick, // external timer clock edge pulse
    output logic unit_output_pin, // output pin level
    output logic unit_output_oe, // output pin drive enable
    output logic converter_trigger, // converter start pulse
    output logic capture_timer_reset, // external timer reset pulse
    output logic unit_event_flag // sticky event flag
);
    timebase_link tb ();

    logic [5:0] control_ff;
    logic [7:0] duty_upper_ff;
    logic [7:0] active_duty_ff;
    logic [1:0] duty_latch_ff;
    logic [7:0] period_limit_ff;
    logic [6:0] period_ctrl_ff;
    logic period_overflow_ff;
    logic event_ff;
    logic pin_dir_ff;
    logic pwm_level_ff;
    logic cmp_latch_ff;
    logic pin_ff;
    logic oe_ff;
    logic [7:0] rdata_ff;
    logic trig_ff;
    logic treset_ff;
    logic treset_pend_ff;
    logic cap_prev_ff;
    logic match_prev_ff;
    logic [3:0] cap_cnt_ff;

    // ------------------------------------------------------------
    // period timer
    // ------------------------------------------------------------
    assign tb.run = period_ctrl_ff[ccp_pkg::RUN_BIT];
    assign tb.sleep = sleep;
    assign tb.prescale_sel = period_ctrl_ff[ccp_pkg::PRESCALE_LSB +: 2];
    assign tb.limit = period_limit_ff;
    assign tb.cnt_wr = wr_stb && addr == ccp_pkg::OFF_PERIOD_COUNT;
    assign tb.cnt_wdata = wdata;

    period_timebase u_timebase (
        .clk(clk),
        .nrst(nrst),
        .tb(tb)
    );

    // ------------------------------------------------------------
    // mode decode
    // ------------------------------------------------------------
    wire [3:0] mode = control_ff[ccp_pkg::MODE_LSB +: 4];
    wire mode_off = mode == ccp_pkg::MODE_OFF;
    wire mode_pwm = mode[3:2] == ccp_pkg::MODE_PWM_TOP;
    wire mode_cap = mode[3:2] == 2'h1;
    wire cap_fall = mode == ccp_pkg::MODE_CAP_FALL;
    wire cmp_toggle = mode == ccp_pkg::MODE_CMP_TOGGLE;
    wire cmp_set = mode == ccp_pkg::MODE_CMP_SET;
    wire cmp_clear = mode == ccp_pkg::MODE_CMP_CLEAR;
    wire cmp_flag = mode == ccp_pkg::MODE_CMP_FLAG;
    wire cmp_trig = mode == ccp_pkg::MODE_CMP_TRIG;
    wire cmp_pin = cmp_toggle || cmp_set || cmp_clear;
    wire mode_cmp = cmp_pin || cmp_flag || cmp_trig;

    // ------------------------------------------------------------
    // bus decode
    // ------------------------------------------------------------
    wire wr_control = wr_stb && addr == ccp_pkg::OFF_UNIT_CONTROL;
    wire wr_upper = wr_stb && addr == ccp_pkg::OFF_DUTY_UPPER;
    wire wr_active = wr_stb && addr == ccp_pkg::OFF_ACTIVE_DUTY && !mode_pwm;
    wire wr_limit = wr_stb && addr == ccp_pkg::OFF_PERIOD_LIMIT;
    wire wr_pctrl = wr_stb && addr == ccp_pkg::OFF_PERIOD_CTRL;
    wire wr_status = wr_stb && addr == ccp_pkg::OFF_STATUS;
    wire wr_pindir = wr_stb && addr == ccp_pkg::OFF_PIN_DIR;
    wire control_cleared = wr_control && wdata[5:0] == 6'h00;
    wire clr_event = wr_status && wdata[ccp_pkg::STAT_EVENT_BIT];
    wire clr_ovf = wr_status && wdata[ccp_pkg::STAT_OVF_BIT];

    // ------------------------------------------------------------
    // pwm compare
    // ------------------------------------------------------------
    wire [9:0] duty_buffered = {duty_upper_ff, control_ff[ccp_pkg::DUTY_LOW_LSB +: 2]};
    wire [9:0] duty_active = {active_duty_ff, duty_latch_ff};
    wire [9:0] time_base = {tb.count, tb.low_bits};
    wire duty_hit = time_base == duty_active;
    wire period_start = tb.period_start && !sleep;

    // ------------------------------------------------------------
    // capture and compare events
    // ------------------------------------------------------------
    wire awake = !sleep;
    wire cap_rise = capture_in && !cap_prev_ff;
    wire cap_fell = !capture_in && cap_prev_ff;
    wire cap_edge = cap_fall ? cap_fell : cap_rise;
    wire cap_event = awake && mode_cap && cap_edge &&
                     (mode == ccp_pkg::MODE_CAP_FALL || mode == ccp_pkg::MODE_CAP_RISE ||
                      (mode == ccp_pkg::MODE_CAP_RISE4 && cap_cnt_ff[1:0] == ccp_pkg::PHASE_LAST) ||
                      (mode == ccp_pkg::MODE_CAP_RISE16 && cap_cnt_ff == ccp_pkg::PRE16_LAST));
    wire [15:0] cmp_value = {active_duty_ff, duty_upper_ff};
    wire match_now = mode_cmp && capture_timer_value == cmp_value;
    wire cmp_event = awake && match_now && !match_prev_ff;
    wire set_event = cap_event || cmp_event;

    // ------------------------------------------------------------
    // output pin selection
    // ------------------------------------------------------------
    wire drives_pin = mode_pwm || cmp_pin;
    wire pin_level = mode_pwm ? pwm_level_ff : cmp_latch_ff;

    // ------------------------------------------------------------
    // read mux
    // ------------------------------------------------------------
    wire [7:0] status_word = {6'h00, period_overflow_ff, event_ff};
    wire [7:0] rd_mux =
        (addr == ccp_pkg::OFF_UNIT_CONTROL) ? {2'h0, control_ff} :
        (addr == ccp_pkg::OFF_DUTY_UPPER) ? duty_upper_ff :
        (addr == ccp_pkg::OFF_ACTIVE_DUTY) ? active_duty_ff :
        (addr == ccp_pkg::OFF_PERIOD_LIMIT) ? period_limit_ff :
        (addr == ccp_pkg::OFF_PERIOD_CTRL) ? {1'b0, period_ctrl_ff} :
        (addr == ccp_pkg::OFF_PERIOD_COUNT) ? tb.count :
        (addr == ccp_pkg::OFF_STATUS) ? status_word :
        (addr == ccp_pkg::OFF_PIN_DIR) ? {7'h00, pin_dir_ff} : 8'h00;

    // ------------------------------------------------------------
    // software registers
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            control_ff <= ccp_pkg::RST_UNIT_CONTROL;
            period_limit_ff <= ccp_pkg::RST_PERIOD_LIMIT;
            period_ctrl_ff <= ccp_pkg::RST_PERIOD_CTRL;
            pin_dir_ff <= ccp_pkg::RST_PIN_DIR;
            rdata_ff <= ccp_pkg::RST_BYTE;
        end else begin
            if (wr_control) begin
                control_ff <= wdata[5:0];
            end
            if (wr_limit) begin
                period_limit_ff <= wdata;
            end
            if (wr_pctrl) begin
                period_ctrl_ff <= wdata[6:0];
            end
            if (wr_pindir) begin
                pin_dir_ff <= wdata[0];
            end
            rdata_ff <= rd_stb ? rd_mux : 8'h00;
        end
    end

    // ------------------------------------------------------------
    // duty and capture registers
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            duty_upper_ff <= ccp_pkg::RST_BYTE;
            active_duty_ff <= ccp_pkg::RST_BYTE;
            duty_latch_ff <= 2'h0;
        end else begin
            if (cap_event) begin
                duty_upper_ff <= capture_timer_value[7:0];
                active_duty_ff <= capture_timer_value[15:8];
            end else begin
                if (wr_upper) begin
                    duty_upper_ff <= wdata;
                end
                if (mode_off) begin
                    active_duty_ff <= ccp_pkg::RST_BYTE;
                    duty_latch_ff <= 2'h0;
                end else if (mode_pwm && period_start) begin
                    active_duty_ff <= duty_buffered[9:2];
                    duty_latch_ff <= duty_buffered[1:0];
                end else if (wr_active) begin
                    active_duty_ff <= wdata;
                end
            end
        end
    end

    // ------------------------------------------------------------
    // pwm and compare output latches
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            pwm_level_ff <= 1'b0;
            cmp_latch_ff <= 1'b0;
        end else begin
            if (!mode_pwm) begin
                pwm_level_ff <= 1'b0;
            end else if (period_start) begin
                pwm_level_ff <= duty_buffered != 10'h000;
            end else if (awake && duty_hit) begin
                pwm_level_ff <= 1'b0;
            end
            if (control_cleared || mode_off) begin
                cmp_latch_ff <= 1'b0;
            end else if (cmp_event && cmp_toggle) begin
                cmp_latch_ff <= !cmp_latch_ff;
            end else if (cmp_event && cmp_set) begin
                cmp_latch_ff <= 1'b1;
            end else if (cmp_event && cmp_clear) begin
                cmp_latch_ff <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // capture prescaler and edge history
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            cap_cnt_ff <= 4'h0;
            cap_prev_ff <= 1'b0;
            match_prev_ff <= 1'b0;
        end else if (awake) begin
            cap_prev_ff <= capture_in;
            match_prev_ff <= match_now;
            if (!mode_cap) begin
                cap_cnt_ff <= 4'h0;
            end else if (cap_rise && !cap_fall) begin
                cap_cnt_ff <= cap_cnt_ff + 4'h1;
            end
        end
    end

    // ------------------------------------------------------------
    // converter trigger and capture timer reset
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            trig_ff <= 1'b0;
            treset_ff <= 1'b0;
            treset_pend_ff <= 1'b0;
        end else begin
            trig_ff <= cmp_event && cmp_trig;
            treset_ff <= treset_pend_ff && capture_timer_tick && match_now;
            if (cmp_event && cmp_trig) begin
                treset_pend_ff <= 1'b1;
            end else if (!match_now || capture_timer_tick) begin
                treset_pend_ff <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // flags, pin and outputs
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            event_ff <= 1'b0;
            period_overflow_ff <= 1'b0;
            pin_ff <= 1'b0;
            oe_ff <= 1'b0;
        end else begin
            if (set_event) begin
                event_ff <= 1'b1;
            end else if (clr_event) begin
                event_ff <= 1'b0;
            end
            if (period_start) begin
                period_overflow_ff <= 1'b1;
            end else if (clr_ovf) begin
                period_overflow_ff <= 1'b0;
            end
            if (awake) begin
                pin_ff <= pin_level;
                oe_ff <= drives_pin && !pin_dir_ff;
            end
        end
    end

    assign rdata = rdata_ff;
    assign unit_output_pin = pin_ff;
    assign unit_output_oe = oe_ff;
    assign converter_trigger = trig_ff;
    assign capture_timer_reset = treset_ff;
    assign unit_event_flag = event_ff;
endmodule : ccp_unit

/* src/ccp_pkg.sv */
package ccp_pkg;
    // ------------------------------------------------------------
    // register offsets
    // ------------------------------------------------------------
    localparam logic [3:0] OFF_UNIT_CONTROL = 4'h0;
    localparam logic [3:0] OFF_DUTY_UPPER = 4'h1;
    localparam logic [3:0] OFF_ACTIVE_DUTY = 4'h2;
    localparam logic [3:0] OFF_PERIOD_LIMIT = 4'h3;
    localparam logic [3:0] OFF_PERIOD_CTRL = 4'h4;
    localparam logic [3:0] OFF_PERIOD_COUNT = 4'h5;
    localparam logic [3:0] OFF_STATUS = 4'h6;
    localparam logic [3:0] OFF_PIN_DIR = 4'h7;
    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [5:0] RST_UNIT_CONTROL = 6'h00;
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [6:0] RST_PERIOD_CTRL = 7'h00;
    localparam logic [7:0] RST_PERIOD_LIMIT = 8'hff;
    localparam logic RST_PIN_DIR = 1'b1;
    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int MODE_LSB = 0;
    localparam int DUTY_LOW_LSB = 4;
    localparam int PRESCALE_LSB = 0;
    localparam int RUN_BIT = 2;
    localparam int POSTSCALE_LSB = 3;
    localparam int STAT_EVENT_BIT = 0;
    localparam int STAT_OVF_BIT = 1;
    // ------------------------------------------------------------
    // mode field codes
    // ------------------------------------------------------------
    localparam logic [3:0] MODE_OFF = 4'h0;
    localparam logic [3:0] MODE_CMP_TOGGLE = 4'h2;
    localparam logic [3:0] MODE_CAP_FALL = 4'h4;
    localparam logic [3:0] MODE_CAP_RISE = 4'h5;
    localparam logic [3:0] MODE_CAP_RISE4 = 4'h6;
    localparam logic [3:0] MODE_CAP_RISE16 = 4'h7;
    localparam logic [3:0] MODE_CMP_SET = 4'h8;
    localparam logic [3:0] MODE_CMP_CLEAR = 4'h9;
    localparam logic [3:0] MODE_CMP_FLAG = 4'ha;
    localparam logic [3:0] MODE_CMP_TRIG = 4'hb;
    localparam logic [1:0] MODE_PWM_TOP = 2'h3;
    // ------------------------------------------------------------
    // prescale codes and counts
    // ------------------------------------------------------------
    localparam logic [1:0] PRESCALE_1 = 2'h0;
    localparam logic [1:0] PRESCALE_4 = 2'h1;
    localparam logic [1:0] PHASE_LAST = 2'h3;
    localparam logic [3:0] PRE16_LAST = 4'hf;
endpackage : ccp_pkg

/* src/timebase_link.sv */
`timescale 1ns/1ps
interface timebase_link;
    logic run;
    logic sleep;
    logic [1:0] prescale_sel;
    logic [7:0] limit;
    logic cnt_wr;
    logic [7:0] cnt_wdata;
    logic [7:0] count;
    logic [1:0] low_bits;
    logic period_start;
    modport timer (input run, sleep, prescale_sel, limit, cnt_wr, cnt_wdata,
                   output count, low_bits, period_start);
    modport user (output run, sleep, prescale_sel, limit, cnt_wr, cnt_wdata,
                  input count, low_bits, period_start);
endinterface : timebase_link

/* src/period_timebase.sv */
`timescale 1ns/1ps
module period_timebase (
    input wire logic clk, // system clock
    input wire logic nrst, // async reset, active low
    timebase_link.timer tb // timer side of the link
);
    logic [1:0] phase_ff;
    logic [3:0] pre_ff;
    logic [7:0] count_ff;
    logic start_ff;

    // ------------------------------------------------------------
    // tick and period decode
    // ------------------------------------------------------------
    wire phase_end = phase_ff == ccp_pkg::PHASE_LAST;
    wire pre_end = (tb.prescale_sel == ccp_pkg::PRESCALE_1) ||
                   (tb.prescale_sel == ccp_pkg::PRESCALE_4 && pre_ff[1:0] == ccp_pkg::PHASE_LAST) ||
                   (tb.prescale_sel[1] && pre_ff == ccp_pkg::PRE16_LAST);
    wire tick = tb.run && phase_end && !tb.sleep;
    wire inc = tick && pre_end;
    wire at_limit = count_ff == tb.limit;

    assign tb.count = count_ff;
    assign tb.period_start = start_ff;
    assign tb.low_bits = (tb.prescale_sel == ccp_pkg::PRESCALE_1) ? phase_ff :
                         (tb.prescale_sel == ccp_pkg::PRESCALE_4) ? pre_ff[1:0] : pre_ff[3:2];

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            phase_ff <= 2'h0;
            pre_ff <= 4'h0;
            count_ff <= 8'h00;
            start_ff <= 1'b0;
        end else begin
            if (!tb.sleep) begin
                phase_ff <= phase_ff + 2'h1;
            end
            if (tb.cnt_wr) begin
                count_ff <= tb.cnt_wdata;
                pre_ff <= 4'h0;
            end else if (inc) begin
                count_ff <= at_limit ? 8'h00 : count_ff + 8'h01;
                pre_ff <= 4'h0;
            end else if (tick) begin
                pre_ff <= pre_ff + 4'h1;
            end
            start_ff <= inc && at_limit && !tb.cnt_wr;
        end
    end
endmodule : period_timebase

/* sim/ccp_unit_assertions.sv */
`timescale 1ns/1ps
module ccp_unit_assertions (
    input wire logic clk, // clock
    input wire logic nrst, // reset
    input wire logic [3:0] addr, // address
    input wire logic [7:0] wdata, // write data
    input wire logic wr_stb, // write
    input wire logic rd_stb, // read
    input wire logic [7:0] rdata, // read data
    input wire logic sleep, // sleep
    input wire logic capture_timer_tick, // tick
    input wire logic unit_output_pin, // pin
    input wire logic unit_output_oe, // enable
    input wire logic converter_trigger, // trigger
    input wire logic capture_timer_reset, // timer reset
    input wire logic unit_event_flag // flag
);
    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);
    chk_ctrl_top_zero: assert property (rd_stb && addr == 4'h0 |=> rdata[7:6] == 2'b00)
        else $error("control top bits set");
    chk_trig_one_cycle: assert property (converter_trigger |=> !converter_trigger)
        else $error("trigger too long");
    chk_treset_one_cycle: assert property (capture_timer_reset |=> !capture_timer_reset)
        else $error("timer reset too long");
    chk_treset_after_tick: assert property (capture_timer_reset |-> $past(capture_timer_tick))
        else $error("timer reset without tick");
    chk_sleep_pin_hold: assert property (sleep [*3] |-> $stable(unit_output_pin))
        else $error("pin moved in sleep");
    chk_reset_pin_input: assert property ($rose(nrst) |-> !unit_output_oe && !unit_output_pin)
        else $error("pin driven after reset");
    chk_off_pin_low: assert property (wr_stb && addr == 4'h0 && wdata[3:0] == 4'h0 |->
        ##[1:3] !unit_output_oe && !unit_output_pin) else $error("pin not released");
    chk_flag_sticky: assert property ($fell(unit_event_flag) |->
        $past(wr_stb) && $past(addr) == 4'h6 && $past(wdata[0])) else $error("flag lost");
endmodule : ccp_unit_assertions

bind ccp_unit ccp_unit_assertions ccp_unit_assertions_i (.clk(clk), .nrst(nrst), .addr(addr),
    .wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata), .sleep(sleep),
    .capture_timer_tick(capture_timer_tick), .unit_output_pin(unit_output_pin),
    .unit_output_oe(unit_output_oe), .converter_trigger(converter_trigger),
    .capture_timer_reset(capture_timer_reset), .unit_event_flag(unit_event_flag));

/* sim/pwm_load.sv */
`timescale 1ns/1ps
module pwm_load (
    input wire logic clk, // clock
    input wire logic pin, // load input
    input wire logic oe, // pin driven
    output int high_len, // last high time
    output int period_len // last rise to rise
);
    int hc = 0;
    int pc = 0;
    logic prev = 1'b0;
    always @(posedge clk) begin
        prev <= pin;
        hc <= pin ? hc + 1 : 0;
        if (prev && !pin) high_len <= hc;
        if (oe && pin && !prev) begin
            period_len <= pc;
            pc <= 1;
        end else pc <= pc + 1;
    end
endmodule : pwm_load

/* sim/ccp_standard_pwm_and_mode_select_bench.sv */
`timescale 1ns/1ps
module ccp_standard_pwm_and_mode_select_bench;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic [3:0] addr = 4'h0;
    logic [7:0] wdata = 8'h00;
    logic wr_stb = 1'b0;
    logic rd_stb = 1'b0;
    logic sleep = 1'b0;
    logic capture_in = 1'b0;
    logic [15:0] tmr_val = 16'h0000;
    logic tick = 1'b0;
    logic tmr_run = 1'b0;
    logic tmr_zero = 1'b0;
    logic [1:0] div = 2'h0;
    logic [7:0] rdata, v, w;
    logic pin, oe, trig, treset, flag;
    logic [1:0] seen;
    int high_len, period_len;
    int n_mismatch = 0;
    int samples_checked = 0;
    ccp_unit ccp_unit_i (.clk(clk), .nrst(nrst), .addr(addr), .wdata(wdata), .wr_stb(wr_stb),
        .rd_stb(rd_stb), .rdata(rdata), .sleep(sleep), .capture_in(capture_in),
        .capture_timer_value(tmr_val), .capture_timer_tick(tick), .unit_output_pin(pin),
        .unit_output_oe(oe), .converter_trigger(trig), .capture_timer_reset(treset),
        .unit_event_flag(flag));
    pwm_load pwm_load_i (.clk(clk), .pin(pin), .oe(oe), .high_len(high_len),
        .period_len(period_len));
    initial forever #50 clk = ~clk;
    // external capture timer, one tick every four clocks
    always @(posedge clk) begin
        div <= div + 2'h1;
        tick <= tmr_run && div == 2'h3;
        if (treset || tmr_zero) tmr_val <= 16'h0000;
        else if (tick) tmr_val <= tmr_val + 16'h0001;
    end
    // ------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------
    task cmp(input logic [15:0] got, input logic [15:0] exp);
        samples_checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("Error t=%0t got %h exp %h", $time, got, exp);
        end
    endtask : cmp
    task wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a; wdata <= d; wr_stb <= 1'b1;
        @(posedge clk);
        wr_stb <= 1'b0;
    endtask : wr
    task rd(input logic [3:0] a, output logic [7:0] d);
        @(posedge clk);
        addr <= a; rd_stb <= 1'b1;
        @(posedge clk);
        rd_stb <= 1'b0;
        #1 d = rdata;
    endtask : rd
    task cyc(input int n);
        repeat (n) @(posedge clk);
    endtask : cyc
    task wait_pin(input logic lvl);
        for (int i = 0; i < 1000 && pin !== lvl; i++) @(posedge clk);
    endtask : wait_pin
    task hold(input logic lvl, input int n);
        int bad;
        bad = 0;
        repeat (n) begin
            @(posedge clk);
            if (pin !== lvl) bad++;
        end
        cmp(16'(bad), 16'h0000);
    endtask : hold
    task print_verdict;
        $display("checked %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : print_verdict
    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task t_reset;
        logic [7:0] exp [9] = '{8'h00, 8'h00, 8'h00, 8'hff, 8'h00, 8'h00, 8'h00, 8'h01, 8'h00};
        for (int i = 0; i < 9; i++) begin
            rd(i[3:0], v);
            cmp(16'(v), 16'(exp[i]));
        end
        wr(4'h0, 8'hff);
        rd(4'h0, v);
        cmp(16'(v), 16'h003f);
        wr(4'h0, 8'h00);
        cyc(4);
    endtask : t_reset
    task t_pwm;
        wr(4'h3, 8'h03);
        wr(4'h1, 8'h02);
        wr(4'h0, 8'h1c);
        wr(4'h6, 8'h02);
        wr(4'h4, 8'h7c);
        v = 8'h00;
        for (int i = 0; i < 100 && v[1] !== 1'b1; i++) rd(4'h6, v);
        wr(4'h7, 8'h00);
        for (int p = 0; p < 3; p++) begin
            wr(4'h4, 8'h7c | p[7:0]);
            cyc(48 << (2 * p));
            cmp(16'(period_len), 16'(16 << (2 * p)));
            cmp(16'(high_len), 16'(9 << (2 * p)));
        end
        wr(4'h4, 8'h7d);
        cyc(192);
        wait_pin(1'b0);
        wait_pin(1'b1);
        wr(4'h1, 8'h03);
        wait_pin(1'b0);
        cyc(2);
        cmp(16'(high_len), 16'd36);
        cyc(128);
        cmp(16'(high_len), 16'd52);
        rd(4'h2, v);
        cmp(16'(v), 16'h0003);
        wr(4'h2, 8'h55);
        rd(4'h2, v);
        cmp(16'(v), 16'h0003);
    endtask : t_pwm
    task t_extreme;
        wr(4'h1, 8'h00);
        wr(4'h0, 8'h0c);
        cyc(130);
        hold(1'b0, 128);
        wr(4'h1, 8'hff);
        cyc(130);
        hold(1'b1, 128);
        sleep <= 1'b1;
        rd(4'h5, v);
        cyc(48);
        rd(4'h5, w);
        cmp(16'(w), 16'(v));
        sleep <= 1'b0;
    endtask : t_extreme
    task t_compare;
        wr(4'h0, 8'h00);
        cyc(4);
        wr(4'h2, 8'h00);
        wr(4'h1, 8'h10);
        tmr_run <= 1'b1;
        tmr_zero <= 1'b1;
        wr(4'h0, 8'h08);
        tmr_zero <= 1'b0;
        wait_pin(1'b1);
        cyc(2);
        cmp(16'({oe, pin, flag}), 16'h0007);
        tmr_zero <= 1'b1;
        wr(4'h0, 8'h02);
        tmr_zero <= 1'b0;
        wait_pin(1'b0);
        cmp(16'(pin), 16'h0000);
        wr(4'h6, 8'h01);
        tmr_zero <= 1'b1;
        wr(4'h0, 8'h0b);
        tmr_zero <= 1'b0;
        seen = 2'b00;
        repeat (200) begin
            @(posedge clk);
            if (trig === 1'b1) seen[0] = 1'b1;
            if (treset === 1'b1) seen[1] = 1'b1;
        end
        cmp(16'(seen), 16'h0003);
        rd(4'h6, v);
        cmp(16'(v[0]), 16'h0001);
        wr(4'h0, 8'h00);
        cyc(4);
        tmr_run <= 1'b0;
        wr(4'h6, 8'h01);
        wr(4'h0, 8'h05);
        capture_in <= 1'b1;
        cyc(4);
        rd(4'h2, v);
        cmp(16'(v), 16'(tmr_val[15:8]));
        rd(4'h1, v);
        cmp(16'(v), 16'(tmr_val[7:0]));
        rd(4'h6, v);
        cmp(16'(v[0]), 16'h0001);
        wr(4'h0, 8'h04);
        wr(4'h6, 8'h01);
        capture_in <= 1'b0;
        cyc(4);
        rd(4'h6, v);
        cmp(16'(v[0]), 16'h0001);
    endtask : t_compare
    initial begin
        repeat (30000) @(posedge clk);
        n_mismatch++;
        print_verdict();
    end
    initial begin
        repeat (5) @(posedge clk);
        nrst <= 1'b1;
        t_reset();
        t_pwm();
        t_extreme();
        t_compare();
        print_verdict();
    end
endmodule : ccp_standard_pwm_and_mode_select_bench
